/* File: btpl_pkg.sv */
// Purpose: Shared constants and types for the breaker trip protection logic
// Assumes: 20 MHz system clock, 12-bit signed sensor samples
// Notes:   Thresholds are compared in the squared domain to avoid a root

package btpl_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_HZ          = 20_000_000;  // System clock rate
  localparam int unsigned BLINK_PERIOD_MS = 1000;        // Status blink period
  localparam int unsigned BLINK_ON_MS     = 100;         // Status lamp on time
  localparam int unsigned BLINK_PERIOD_CYC = BLINK_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned BLINK_ON_CYC     = BLINK_ON_MS * (CLK_HZ / 1000);
  localparam int          BL_W             = 25;         // Blink counter width

  // ************************************************************
  // Sampling and arithmetic widths
  // ************************************************************
  localparam int SMP_W   = 12;  // Sample width, signed
  localparam int SQ_W    = 24;  // Square of a sample
  localparam int ACC_W   = 28;  // Window sum of squares
  localparam int CNT_W   = 16;  // Line cycle delay counters
  localparam int NCH     = 5;   // Scanned channels
  localparam int CH_W    = 3;   // Channel index width
  localparam int WIN_LOG = 4;   // Log2 of sweeps per RMS window

  localparam logic [CH_W-1:0]    CH_A     = 3'h0;  // Phase A
  localparam logic [CH_W-1:0]    CH_B     = 3'h1;  // Phase B
  localparam logic [CH_W-1:0]    CH_C     = 3'h2;  // Phase C
  localparam logic [CH_W-1:0]    CH_GND   = 3'h3;  // Ground, when fitted
  localparam logic [CH_W-1:0]    CH_PLUG  = 3'h4;  // Rating plug
  localparam logic [WIN_LOG-1:0] WIN_LAST = 4'hf;  // Last sweep of a window

  // ************************************************************
  // Protection constants
  // ************************************************************
  localparam logic [7:0]  TEMP_LIMIT_C = 8'h5f;  // 95 degC chip limit
  localparam logic [7:0]  MAKE_MULT    = 8'h0b;  // Release at 11 x plug current
  localparam logic [7:0]  LOAD_PCT     = 8'h0a;  // Live load at 10 % of sensor
  localparam logic [7:0]  PCT_FULL     = 8'h64;  // 100 %
  localparam logic [3:0]  ARM_CYCLES   = 4'ha;   // Release window in line cycles
  localparam logic [2:0]  SEL_BLANK    = 3'h7;   // Selector blank position
  localparam logic [3:0]  ZI_WAIT      = 4'h8;   // Wait for a looped restraint

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic [SMP_W-1:0] long_pu;     // Long delay pickup
    logic [SMP_W-1:0] short_pu;    // Short delay pickup
    logic [SMP_W-1:0] gnd_pu;      // Ground fault pickup
    logic [SMP_W-1:0] instant_pu;  // Adjustable instantaneous pickup
    logic [SMP_W-1:0] ovr_pu;      // Fixed override threshold
    logic [SMP_W-1:0] sensor_rt;   // Sensor rating
    logic [CNT_W-1:0] long_cyc;    // Long delay, line cycles
    logic [CNT_W-1:0] short_cyc;   // Short delay, line cycles
    logic [CNT_W-1:0] gnd_cyc;     // Ground delay, line cycles
  } btpl_set_t;

  typedef struct packed {
    logic adjustable_instantaneous_protection;  // Variant has instantaneous
    logic has_short;                            // Short delay fitted
    logic has_gnd;                              // Ground fault fitted
    logic zi_en;                                // Zone interlock wired
  } btpl_cfg_t;

  typedef struct packed {
    logic long_time;   // Long delay or over temperature cause
    logic short_time;  // Short delay cause
    logic instant;     // Instantaneous, override or release cause
    logic ground;      // Ground fault cause
  } btpl_led_t;

  typedef enum logic {ST_RUN, ST_TRIPPED} btpl_state_t;

endpackage

/* File: btpl_smp_mem.sv */
// Purpose: Working memory holding the latest sample of each channel
// Assumes: One write and one read port on the system clock
// Notes:   Read data are registered, one cycle behind the address

`timescale 1ns/10ps

module btpl_smp_mem #(
  parameter int W = btpl_pkg::SMP_W,  // Word width
  parameter int D = btpl_pkg::NCH,    // Word count
  parameter int A = btpl_pkg::CH_W    // Address width
) (
  input  wire logic         i_clk,    // System clock
  input  wire logic         i_rst_n,  // Synchronous reset, active low
  input  wire logic         i_we,     // Write strobe
  input  wire logic [A-1:0] i_waddr,  // Write address
  input  wire logic [W-1:0] i_wdata,  // Write data
  input  wire logic [A-1:0] i_raddr,  // Read address
  output logic      [W-1:0] o_rdata   // Registered read data
);

  logic [W-1:0] mem_q [D];  // Storage, no reset needed

  // ************************************************************
  // Write port
  // ************************************************************
  always_ff @(posedge i_clk)
  begin
    if (i_we && (int'(i_waddr) < D))
    begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  // ************************************************************
  // Registered read port
  // ************************************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= '0;
    end
    else
    begin
      o_rdata <= (int'(i_raddr) < D) ? mem_q[i_raddr] : '0;
    end
  end

endmodule

/* File: btpl_top.sv */
// Purpose: Trip decision, release arming, zone interlock and lamps
// Assumes: Samples and settings come from logic on the same clock
// Notes:   Trip and cause lamps latch until reset; backup power holds them

`timescale 1ns/10ps

module btpl_top #(
  parameter int unsigned BLINK_CYC = btpl_pkg::BLINK_PERIOD_CYC,  // Blink period
  parameter int unsigned BLON_CYC  = btpl_pkg::BLINK_ON_CYC       // Lamp on time
) (
  input  wire logic                      i_clk,       // 20 MHz clock
  input  wire logic                      i_rst_n,     // Sync reset, active low
  input  wire logic                      i_smp_we,    // New digitized sample
  input  wire logic [btpl_pkg::CH_W-1:0]  i_smp_ch,    // Sample channel
  input  wire logic [btpl_pkg::SMP_W-1:0] i_smp_val,   // Signed sample value
  input  wire logic [7:0]                i_temp_c,    // Chip temperature
  input  wire btpl_pkg::btpl_set_t        i_set,       // Protection settings
  input  wire btpl_pkg::btpl_cfg_t        i_cfg,       // Variant and options
  input  wire logic                      i_ready,     // Self check good
  input  wire logic [2:0]                i_ovr_sel,   // Override selector pin
  input  wire logic                      i_zi_in,     // Restraint input pin
  output btpl_pkg::btpl_led_t             o_led,       // Cause lamps
  output logic                           o_trip,      // Trip actuator drive
  output logic                           o_led_status,// Status lamp
  output logic                           o_zi_out,    // Restraint output
  output logic                           o_rel_armed  // Release armed
);

  localparam int SW = btpl_pkg::SQ_W;
  localparam int AW = btpl_pkg::ACC_W;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q;  // Three stage chain
  logic [3:0] pin_q;                         // Accepted pin levels
  wire  [2:0] sel     = pin_q[3:1];           // Override selector
  wire        restr   = pin_q[0];             // Restraint present

  // A change is accepted only when the last two stages agree
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      pin_s3_q <= 4'h0;
      pin_q    <= 4'h0;
    end
    else
    begin
      pin_s1_q <= {i_ovr_sel, i_zi_in};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (pin_s2_q == pin_s3_q)
      begin
        pin_q <= pin_s3_q;
      end
    end
  end

  // ************************************************************
  // Sample memory and cyclic scan
  // ************************************************************
  logic [btpl_pkg::CH_W-1:0]    rd_ch_q;   // Channel being read
  logic [btpl_pkg::CH_W-1:0]    dat_ch_q;  // Channel of read data
  logic [btpl_pkg::SMP_W-1:0]   rd_data;   // Read data from memory
  logic [btpl_pkg::WIN_LOG-1:0] sweep_q;   // Sweeps inside window
  logic [AW-1:0]               acc_q [btpl_pkg::NCH];  // Sums of squares
  logic [SW-1:0]               ms_q  [btpl_pkg::NCH];  // Mean squares
  logic                        sign_q;    // Last phase A sign
  logic                        cyc_q;     // One line cycle seen

  btpl_smp_mem btpl_smp_mem_adjustable_instantaneous_protection (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_we    (i_smp_we),
    .i_waddr (i_smp_ch),
    .i_wdata (i_smp_val),
    .i_raddr (rd_ch_q),
    .o_rdata (rd_data)
  );

  wire signed [SW-1:0] sq_s  = $signed(rd_data) * $signed(rd_data);
  wire        [AW-1:0] sq_x  = {{(AW-SW){1'b0}}, sq_s};
  wire        rd_last  = (rd_ch_q == btpl_pkg::CH_PLUG);
  wire        dat_last = (dat_ch_q == btpl_pkg::CH_PLUG);
  wire        win_end  = dat_last && (sweep_q == btpl_pkg::WIN_LAST);
  wire        dat_a    = (dat_ch_q == btpl_pkg::CH_A);
  wire        neg_now  = rd_data[btpl_pkg::SMP_W-1];

  // Scan address walks every channel, data lag by one cycle
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      rd_ch_q  <= btpl_pkg::CH_A;
      dat_ch_q <= btpl_pkg::CH_PLUG;
      sweep_q  <= '0;
      sign_q   <= 1'b0;
      cyc_q    <= 1'b0;
    end
    else
    begin
      rd_ch_q  <= rd_last ? btpl_pkg::CH_A : rd_ch_q + 3'h1;
      dat_ch_q <= rd_ch_q;
      if (dat_last)
      begin
        sweep_q <= sweep_q + 4'h1;
      end
      // Negative to positive on phase A marks one line cycle
      cyc_q <= dat_a && sign_q && !neg_now;
      if (dat_a)
      begin
        sign_q <= neg_now;
      end
    end
  end

  // One accumulator per channel; windows close on the last sweep
  for (genvar k = 0; k < btpl_pkg::NCH; k++)
  begin : g_acc
    wire [AW-1:0] sum = acc_q[k] + ((int'(dat_ch_q) == k) ? sq_x : '0);
    always_ff @(posedge i_clk)
    begin
      if (!i_rst_n)
      begin
        acc_q[k] <= '0;
        ms_q[k]  <= '0;
      end
      else if (win_end)
      begin
        ms_q[k]  <= sum[AW-1:btpl_pkg::WIN_LOG];
        acc_q[k] <= '0;
      end
      else
      begin
        acc_q[k] <= sum;
      end
    end
  end

  // ************************************************************
  // Pickup decisions, squared domain
  // ************************************************************
  function automatic logic [SW-1:0] sqr(input logic [btpl_pkg::SMP_W-1:0] v);
    sqr = v * v;
  endfunction

  wire [SW-1:0] ab_ms  = (ms_q[0] > ms_q[1]) ? ms_q[0] : ms_q[1];
  wire [SW-1:0] ph_ms  = (ab_ms > ms_q[2]) ? ab_ms : ms_q[2];
  wire [SW-1:0] gd_ms  = ms_q[btpl_pkg::CH_GND];
  wire [SW-1:0] pl_ms  = ms_q[btpl_pkg::CH_PLUG];
  wire [31:0]   pct_sq = 32'(btpl_pkg::PCT_FULL) * 32'(btpl_pkg::PCT_FULL);
  wire [31:0]   lp_sq  = 32'(btpl_pkg::LOAD_PCT) * 32'(btpl_pkg::LOAD_PCT);
  wire [31:0]   mk_sq  = 32'(btpl_pkg::MAKE_MULT) * 32'(btpl_pkg::MAKE_MULT);
  wire [47:0]   ld_lhs = 48'(ph_ms) * 48'(pct_sq);
  wire [47:0]   ld_rhs = 48'(sqr(i_set.sensor_rt)) * 48'(lp_sq);
  wire [47:0]   mk_rhs = 48'(pl_ms) * 48'(mk_sq);
  wire          aip    = i_cfg.adjustable_instantaneous_protection;

  wire load_on  = ld_lhs > ld_rhs;
  wire long_pu  = ph_ms > sqr(i_set.long_pu);
  wire short_pu = i_cfg.has_short && (ph_ms > sqr(i_set.short_pu));
  wire gnd_pu   = i_cfg.has_gnd && (gd_ms > sqr(i_set.gnd_pu));
  wire adjustable_instantaneous_protection_pu  = aip && (ph_ms > sqr(i_set.instant_pu));
  wire ovr_pu   = !aip && (ph_ms > sqr(i_set.ovr_pu));
  wire make_pu  = 48'(ph_ms) > mk_rhs;
  wire temp_hot = i_temp_c > btpl_pkg::TEMP_LIMIT_C;
  wire zi_act   = i_cfg.zi_en && (i_cfg.has_short || i_cfg.has_gnd);
  wire zone_flt = short_pu || gnd_pu;

  // ************************************************************
  // Making current release arming
  // ************************************************************
  logic [3:0] arm_cnt_q;  // Loaded cycles since arming
  wire armed   = arm_cnt_q < btpl_pkg::ARM_CYCLES;
  wire rel_on  = !aip && (sel != btpl_pkg::SEL_BLANK);
  wire rel_act = rel_on && armed;
  wire make_tr = rel_act && make_pu;

  // Light load re-arms; loaded line cycles run the window out
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      arm_cnt_q <= 4'h0;
    end
    else if (!load_on)
    begin
      arm_cnt_q <= 4'h0;
    end
    else if (cyc_q && armed)
    begin
      arm_cnt_q <= arm_cnt_q + 4'h1;
    end
  end

  // ************************************************************
  // Delay counters and zone interlock
  // ************************************************************
  logic [btpl_pkg::CNT_W-1:0] long_cnt_q, short_cnt_q, gnd_cnt_q;  // Cycles
  logic [3:0]                 zone_cnt_q;  // Clocks since zone fault

  wire long_tr  = long_pu && (long_cnt_q >= i_set.long_cyc);
  wire short_tr = short_pu && (short_cnt_q >= i_set.short_cyc);
  wire gnd_tr   = gnd_pu && (gnd_cnt_q >= i_set.gnd_cyc);
  // The wait lets a looped restraint arrive before a fast trip
  wire zone_ok  = zone_cnt_q >= btpl_pkg::ZI_WAIT;
  wire zone_tr  = zi_act && zone_flt && zone_ok && !restr;
  wire fast_tr  = adjustable_instantaneous_protection_pu || ovr_pu || make_tr;

  // Counters run only while their own pickup holds
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      long_cnt_q  <= '0;
      short_cnt_q <= '0;
      gnd_cnt_q   <= '0;
      zone_cnt_q  <= '0;
    end
    else
    begin
      long_cnt_q  <= !long_pu ? '0 : long_cnt_q + 16'(cyc_q && !(&long_cnt_q));
      short_cnt_q <= !short_pu ? '0 : short_cnt_q + 16'(cyc_q && !(&short_cnt_q));
      gnd_cnt_q   <= !gnd_pu ? '0 : gnd_cnt_q + 16'(cyc_q && !(&gnd_cnt_q));
      zone_cnt_q  <= !zone_flt ? '0 : zone_cnt_q + 4'(!zone_ok);
    end
  end

  // ************************************************************
  // Trip state and outputs
  // ************************************************************
  localparam int BL_W_L = btpl_pkg::BL_W;
  btpl_pkg::btpl_state_t st_q;  // Running or tripped
  logic [BL_W_L-1:0] bl_cnt_q;  // Free running blink timebase

  wire trip_req = temp_hot || long_tr || short_tr || gnd_tr || zone_tr || fast_tr;
  wire bl_wrap  = bl_cnt_q == BL_W_L'(BLINK_CYC - 1);
  wire bl_on    = bl_cnt_q < BL_W_L'(BLON_CYC);

  // Trip latches with every cause present at that moment
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_q   <= btpl_pkg::ST_RUN;
      o_trip <= 1'b0;
      o_led  <= '0;
    end
    else
    begin
      case (st_q)
        btpl_pkg::ST_RUN:
        begin
          if (trip_req)
          begin
            st_q             <= btpl_pkg::ST_TRIPPED;
            o_trip           <= 1'b1;
            o_led.long_time  <= temp_hot || long_tr;
            o_led.short_time <= short_tr || (zone_tr && short_pu);
            o_led.instant    <= fast_tr;
            o_led.ground     <= gnd_tr || (zone_tr && gnd_pu);
          end
        end
        btpl_pkg::ST_TRIPPED:
        begin
          st_q <= btpl_pkg::ST_TRIPPED;  // Held by backup power
        end
        default:
        begin
          st_q <= btpl_pkg::ST_RUN;
        end
      endcase
    end
  end

  // Status lamp, restraint output and arming flag
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      bl_cnt_q     <= '0;
      o_led_status <= 1'b1;
      o_zi_out     <= 1'b0;
      o_rel_armed  <= 1'b0;
    end
    else
    begin
      bl_cnt_q     <= bl_wrap ? '0 : bl_cnt_q + 1'b1;
      o_led_status <= !i_ready || (load_on && bl_on);
      o_zi_out     <= zi_act && zone_flt;
      o_rel_armed  <= rel_act;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire run = st_q == btpl_pkg::ST_RUN;

  chk_temp_trip: assert property (run && temp_hot |=> o_trip)
    else $error("over temperature did not trip");
  chk_temp_lamp: assert property (run && temp_hot |=> o_led.long_time)
    else $error("over temperature lamp missing");
  chk_scan_wrap: assert property (rd_last |=> rd_ch_q == btpl_pkg::CH_A ##1 rd_ch_q == btpl_pkg::CH_B)
    else $error("scan order broken");
  chk_long_trip: assert property (run && long_tr |=> o_trip)
    else $error("long delay did not trip");
  chk_ovr_trip: assert property (run && ovr_pu |=> o_trip && o_led.instant)
    else $error("override did not trip");
  chk_zi_gate: assert property (!i_cfg.has_short && !i_cfg.has_gnd |=> !o_zi_out)
    else $error("interlock output without short or ground");
  chk_zone_fast: assert property (run && zone_tr |=> o_trip)
    else $error("in zone fault not tripped");
  chk_zi_drive: assert property (zi_act && zone_flt |=> o_zi_out)
    else $error("restraint output not driven");
  chk_restr_hold: assert property (run && restr && !short_tr && !gnd_tr && !long_tr
    && !fast_tr && !temp_hot |=> !o_trip)
    else $error("restrained unit tripped early");
  chk_latch_lamp: assert property (!run |=> $stable(o_led) && o_trip)
    else $error("cause lamps changed after trip");
  chk_not_ready: assert property (!i_ready |=> o_led_status)
    else $error("status lamp not steady");
  chk_rearm: assert property (!load_on |=> arm_cnt_q == 4'h0)
    else $error("release not re-armed");
  chk_make_trip: assert property (run && make_tr |=> o_trip && o_led.instant)
    else $error("release did not trip");
  chk_blank_off: assert property (sel == btpl_pkg::SEL_BLANK |=> !o_rel_armed)
    else $error("blank position left release armed");

  cov_make_trip: cover property (run && make_tr ##1 o_trip);
  cov_zone_trip: cover property (run && zone_tr ##1 o_trip);
  cov_blink:     cover property (i_ready && load_on && bl_wrap);
  cov_temp_trip: cover property (run && temp_hot ##1 o_led.long_time);

endmodule

/* File: btpl_zone_peer.sv */
// Purpose: Zone interlock wiring as seen from the neighbouring trip unit
// Assumes: Same clock as the unit under test
// Notes:   Either loops the unit's own output back or sends a restraint

`timescale 1ns/10ps

module btpl_zone_peer (
  input  wire logic i_clk,       // System clock
  input  wire logic i_zi_out,    // Restraint sent by the unit
  input  wire logic i_loop,      // Jumper fitted across the terminals
  input  wire logic i_restrain,  // Downstream unit restrains
  output logic      o_zi_in      // Restraint seen by the unit
);
  // ************************************************************
  // Wiring
  // ************************************************************
  // Registered, so a looped jumper never forms a zero delay path
  always_ff @(posedge i_clk)
  begin
    o_zi_in <= i_loop ? i_zi_out : i_restrain;
  end
endmodule

/* File: btpl_top_test.sv */
// Purpose: Self-checking bench for the trip decision logic
// Assumes: Short blink period; samples held constant, so no zero crossings
// Notes:   Line cycle arming counts are not exercised with constant samples

`timescale 1ns/10ps

module btpl_top_test;
  // ************************************************************
  // Signals
  // ************************************************************
  logic                   clk, rst_n, smp_we, ready, loop_en, restrain, zi_in, hit;
  logic [2:0]             smp_ch, ovr_sel;
  logic [11:0]            smp_val;
  logic [7:0]             temp_c;
  btpl_pkg::btpl_set_t    set;
  btpl_pkg::btpl_cfg_t    cfg;
  btpl_pkg::btpl_led_t    led;
  logic                   trip, led_status, zi_out, rel_armed;
  int                     miscompares, comparisons, cycles, cnt;

  btpl_top #(.BLINK_CYC(100), .BLON_CYC(10)) btpl_top_adjustable_instantaneous_protection (
    .i_clk(clk), .i_rst_n(rst_n), .i_smp_we(smp_we), .i_smp_ch(smp_ch),
    .i_smp_val(smp_val), .i_temp_c(temp_c), .i_set(set), .i_cfg(cfg),
    .i_ready(ready), .i_ovr_sel(ovr_sel), .i_zi_in(zi_in), .o_led(led),
    .o_trip(trip), .o_led_status(led_status), .o_zi_out(zi_out),
    .o_rel_armed(rel_armed));

  btpl_zone_peer btpl_zone_peer_adjustable_instantaneous_protection (
    .i_clk(clk), .i_zi_out(zi_out), .i_loop(loop_en), .i_restrain(restrain),
    .o_zi_in(zi_in));

  // ************************************************************
  // Clock and hang guard
  // ************************************************************
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Whole run needs well under this many cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Reset with quiet settings: high pickups, endless delays
  task automatic restart(input logic adj, input logic [2:0] sel);
    @(posedge clk);
    rst_n    <= 1'b0;
    set      <= '{12'h7ff, 12'h7ff, 12'h7ff, 12'h7ff, 12'h7ff, 12'h3e8,
                  16'hffff, 16'hffff, 16'hffff};
    cfg      <= '{adj, 1'b0, 1'b0, 1'b0};
    ovr_sel  <= sel;
    temp_c   <= 8'h19;
    restrain <= 1'b0;
    loop_en  <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  // Writes phases, ground and plug; memory keeps them
  task automatic load(input logic [11:0] ph, input logic [11:0] plug);
    for (int ch = 0; ch < 5; ch++)
    begin
      @(posedge clk);
      smp_we  <= 1'b1;
      smp_ch  <= ch[2:0];
      smp_val <= (ch == 4) ? plug : ((ch == 3) ? 12'h000 : ph);
    end
    @(posedge clk);
    smp_we <= 1'b0;
    // Step off the edge so outputs launched there have settled
    #1;
  endtask

  task automatic wait_trip(input int n);
    hit = 1'b0;
    for (int i = 0; i < n && !hit; i++)
    begin
      @(posedge clk);
      #1 hit = (trip === 1'b1);
    end
  endtask

  task automatic count_status(input int n);
    cnt = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1 cnt += (led_status === 1'b1);
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_temp();
    restart(1'b1, 3'h0);
    load(12'h005, 12'h00a);
    check({trip, zi_out, rel_armed, led_status}, 8'h00, "reset outputs");
    temp_c <= 8'h5f;
    wait_trip(30);
    check(hit, 8'h00, "trip at limit");
    temp_c <= 8'h60;
    wait_trip(3);
    check(hit, 8'h01, "overtemperature trip");
    check({4'h0, led}, 8'h08, "overtemperature lamp");
  endtask

  task automatic t_release();
    restart(1'b0, 3'h0);
    load(12'h0c8, 12'h00a);
    check(rel_armed, 8'h01, "release armed");
    wait_trip(200);
    check(hit, 8'h01, "release trip");
    check({4'h0, led}, 8'h02, "release lamp");
  endtask

  task automatic t_blank();
    restart(1'b0, 3'h7);
    load(12'h0c8, 12'h00a);
    wait_trip(300);
    check({hit, rel_armed}, 8'h00, "blank selector");
    set.ovr_pu <= 12'h096;
    wait_trip(200);
    check(hit, 8'h01, "override trip");
    check({4'h0, led}, 8'h02, "override lamp");
  endtask

  task automatic t_zone(input logic looped);
    restart(1'b1, 3'h0);
    cfg      <= '{1'b1, 1'b1, 1'b0, 1'b1};
    set.short_pu <= 12'h064;
    restrain <= 1'b1;
    loop_en  <= looped;
    load(12'h005, 12'h00a);
    wait_trip(200);
    check({hit, zi_out}, 8'h00, "restraint alone");
    load(12'h0c8, 12'h00a);
    wait_trip(300);
    check({hit, zi_out}, 8'h01, "restrained zone fault");
    if (!looped)
    begin
      restrain <= 1'b0;
      wait_trip(40);
      check(hit, 8'h01, "in-zone fast trip");
      check({4'h0, led}, 8'h04, "zone lamp");
      check(zi_out, 8'h01, "restraint sent");
    end
  endtask

  task automatic t_status();
    restart(1'b1, 3'h0);
    ready <= 1'b0;
    load(12'h0c8, 12'h00a);
    count_status(200);
    check(cnt[7:0], 8'hc8, "not ready steady");
    ready <= 1'b1;
    repeat (10) @(posedge clk);
    count_status(100);
    check(cnt[7:0], 8'h0a, "blink per period");
    load(12'h005, 12'h00a);
    repeat (200) @(posedge clk);
    count_status(100);
    check(cnt[7:0], 8'h00, "light load dark");
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    {rst_n, smp_we, smp_ch, smp_val, ovr_sel, restrain, loop_en} = '0;
    {miscompares, comparisons, cycles} = '0;
    ready  = 1'b1;
    temp_c = 8'h19;
    set    = '0;
    cfg    = '0;
    repeat (3) @(posedge clk);
    t_temp();
    t_release();
    t_blank();
    t_zone(1'b0);
    t_zone(1'b1);
    t_status();
    end_of_test();
  end
endmodule
